// ===== verilog/iic_cfg.svh
// offsets, reset values and timing counts of the two-wire interface
`ifndef IIC_CFG_SVH
`define IIC_CFG_SVH

// register indexes, byte address is four times the index
`define IIC_IDX_CR 3'h0
`define IIC_IDX_SR1 3'h1
`define IIC_IDX_SR2 3'h2
`define IIC_IDX_CCR 3'h3
`define IIC_IDX_OAR 3'h4
`define IIC_IDX_DR 3'h5
`define IIC_IDX_LAST 6'h05

// field positions
`define IIC_CR_PE_BIT 5
`define IIC_CR_W 6

// reset values
`define IIC_CR_RST 6'h00
`define IIC_CCR_RST 8'h00
`define IIC_OAR_RST 8'h00
`define IIC_DR_RST 8'h00

// address patterns
`define IIC_GC_ADDR 8'h00
`define IIC_IGN_ADDR 8'h01
`define IIC_HDR_PAT 5'h1e

// bit counter marks
`define IIC_BUS_ERROR_FLAG_LO 4'h2
`define IIC_ACK_BIT 4'h8
`define IIC_END_BIT 4'h9

// least divider limit, a bus clock phase lasts at least five pclk cycles, covers synchroniser delay
`define IIC_DIV_MIN 8'h04

`endif

// ===== verilog/iic_pkg.sv
// types shared by the two-wire interface control logic
package iic_pkg;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SETUP,
		ST_START1,
		ST_START2,
		ST_XFER,
		ST_RSTART,
		ST_STOP1,
		ST_STOP2
	} iic_state_e;

	typedef struct packed {
		logic unit_enable;
		logic broadcast_accept;
		logic start_req;
		logic ack_en;
		logic stop_req;
		logic irq_enable;
	} iic_ctrl_s;

	typedef struct packed {
		logic ten_bit_header_sent;
		logic direction_sent_flag;
		logic bus_busy;
		logic byte_done;
		logic addressed_as_target;
		logic controller_role;
		logic start_sent;
	} iic_sr1_s;

	typedef struct packed {
		logic ack_failure;
		logic stop_seen;
		logic arbitration_lost;
		logic bus_error_flag;
		logic broadcast_addressed;
	} iic_sr2_s;

	typedef struct packed {
		logic xfer;
		logic addr_ph;
		logic hdr;
		logic tx;
		logic tgt_sel;
		logic tx_wait;
		logic ev6;
		logic ackok;
		logic sda_low;
		logic clk_low;
		logic [3:0] cnt;
		logic [7:0] sh;
	} iic_eng_s;

endpackage : iic_pkg

// ===== verilog/iic_ctrl.sv
// two-wire bus control and status logic with apb register access
`timescale 1ns/1ps
`include "iic_cfg.svh"

module iic_ctrl (
	input wire logic pclk, // system clock
	input wire logic presetn, // async reset
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [7:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error
	input wire logic scl_i, // bus clock level
	output logic scl_o, // bus clock drive value
	output logic scl_oe_n, // bus clock pull low
	input wire logic sda_i, // bus data level
	output logic sda_o, // bus data drive value
	output logic sda_oe_n, // bus data pull low
	output logic irq // interrupt request
);

	function automatic logic [3:0] iic_dec(input logic [7:0] a);
		iic_dec = {(a[1:0] == 2'h0) && (a[7:2] <= `IIC_IDX_LAST), a[4:2]};
	endfunction : iic_dec

	iic_pkg::iic_ctrl_s cr_q, cr_d;
	iic_pkg::iic_sr1_s s1_q, s1_d;
	iic_pkg::iic_sr2_s s2_q, s2_d;
	iic_pkg::iic_eng_s eng_q, eng_d;
	iic_pkg::iic_state_e st_q, st_d;
	logic [7:0] dr_q, dr_d, oar_q, oar_d, ccr_q, ccr_d, div_q, div_d, limit, rd_mux;
	logic [31:0] prdata_q, prdata_d;
	logic s1rd_q, s1rd_d, s2rd_q, s2rd_d, irq_q, irq_d;
	logic scl_oe_n_q, sda_oe_n_q, scl_low, sda_low;
	logic scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
	logic scl_rise, scl_fall, start_det, stop_det, tick, hold, is_gc, match, ev_any;
	logic misplaced, apb_wr, apb_rd, hit_ok, setup_rd, role;
	logic [3:0] dec_a;
	logic [2:0] hit_idx;

	// bus pins, two stages before use
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scl_m_q <= 1'b1;
			scl_s_q <= 1'b1;
			scl_p_q <= 1'b1;
			sda_m_q <= 1'b1;
			sda_s_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_m_q <= scl_i;
			scl_s_q <= scl_m_q;
			scl_p_q <= scl_s_q;
			sda_m_q <= sda_i;
			sda_s_q <= sda_m_q;
			sda_p_q <= sda_s_q;
		end
	end

	assign scl_rise = scl_s_q && !scl_p_q;
	assign scl_fall = !scl_s_q && scl_p_q;
	assign start_det = scl_s_q && scl_p_q && sda_p_q && !sda_s_q;
	assign stop_det = scl_s_q && scl_p_q && !sda_p_q && sda_s_q;
	assign misplaced = eng_q.xfer && (eng_q.cnt >= `IIC_BUS_ERROR_FLAG_LO) && (eng_q.cnt <= `IIC_ACK_BIT);

	assign limit = (ccr_q[7] ? {2'h0, ccr_q[6:1]} : {1'b0, ccr_q[6:0]}) + `IIC_DIV_MIN;
	assign tick = (div_q == limit);
	assign role = s1_q.controller_role;

	assign is_gc = (eng_q.sh == `IIC_GC_ADDR) && cr_q.broadcast_accept;
	assign match = ((eng_q.sh[7:1] == oar_q[7:1]) && (eng_q.sh != `IIC_IGN_ADDR)
		&& (eng_q.sh != `IIC_GC_ADDR)) || is_gc;

	assign hold = s1_q.ten_bit_header_sent || s1_q.start_sent || s1_q.byte_done
		|| s1_q.addressed_as_target || eng_q.ev6 || eng_q.tx_wait;
	assign ev_any = hold || (|s2_q[4:1]);

	assign dec_a = iic_dec(paddr);
	assign hit_ok = dec_a[3];
	assign hit_idx = dec_a[2:0];
	assign apb_wr = psel && penable && pwrite && hit_ok;
	assign apb_rd = psel && penable && !pwrite && hit_ok;
	assign setup_rd = psel && !penable && !pwrite;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit_ok;

	always_comb begin
		case (hit_idx)
			`IIC_IDX_CR: rd_mux = {2'h0, cr_q};
			`IIC_IDX_SR1: rd_mux = {ev_any, s1_q};
			`IIC_IDX_SR2: rd_mux = {3'h0, s2_q};
			`IIC_IDX_CCR: rd_mux = ccr_q;
			`IIC_IDX_OAR: rd_mux = oar_q;
			`IIC_IDX_DR: rd_mux = dr_q;
			default: rd_mux = 8'h00;
		endcase
	end

	always_comb begin
		cr_d = cr_q;
		s1_d = s1_q;
		s2_d = s2_q;
		eng_d = eng_q;
		st_d = st_q;
		dr_d = dr_q;
		oar_d = oar_q;
		ccr_d = ccr_q;
		s1rd_d = s1rd_q;
		s2rd_d = s2rd_q;
		div_d = tick ? 8'h00 : div_q + 8'h01;
		// unmapped reads return zero, not the previous word
		prdata_d = setup_rd ? {24'h0, hit_ok ? rd_mux : 8'h00} : prdata_q;

		// software accesses and their clearing sequences
		if (apb_wr && hit_idx == `IIC_IDX_CR) begin
			if (!cr_q.unit_enable) begin
				cr_d.unit_enable = pwdata[`IIC_CR_PE_BIT];
			end else begin
				cr_d = iic_pkg::iic_ctrl_s'(pwdata[`IIC_CR_W-1:0]);
				if (cr_d.start_req && cr_d.unit_enable) begin
					s1_d.controller_role = 1'b1;
				end
				if (s1rd_q) begin
					eng_d.ev6 = 1'b0;
					// transmitter keeps clock low until first data byte is written
					if (eng_q.ev6 && eng_q.tx) begin
						eng_d.tx_wait = 1'b1;
					end
				end
			end
			s1rd_d = 1'b0;
		end
		if (apb_wr && hit_idx == `IIC_IDX_CCR) begin
			ccr_d = pwdata[7:0];
		end
		if (apb_wr && hit_idx == `IIC_IDX_OAR) begin
			oar_d = pwdata[7:0];
		end
		if (apb_wr && hit_idx == `IIC_IDX_DR) begin
			dr_d = pwdata[7:0];
			eng_d.sh = pwdata[7:0];
			eng_d.tx_wait = 1'b0;
			eng_d.sda_low = !pwdata[7] && (s1_q.start_sent || eng_q.tx);
			if (s1rd_q) begin
				if (s1_q.start_sent) begin
					eng_d.tx = 1'b1;
				end
				s1_d.start_sent = 1'b0;
				s1_d.byte_done = 1'b0;
				s1_d.direction_sent_flag = 1'b0;
			end
			if (s2rd_q) begin
				s1_d.ten_bit_header_sent = 1'b0;
			end
			s1rd_d = 1'b0;
			s2rd_d = 1'b0;
		end
		if (apb_rd && hit_idx == `IIC_IDX_DR) begin
			if (s1rd_q) begin
				s1_d.byte_done = 1'b0;
				s1_d.direction_sent_flag = 1'b0;
			end
			s1rd_d = 1'b0;
		end
		if (apb_rd && hit_idx == `IIC_IDX_SR1) begin
			s1rd_d = 1'b1;
			s1_d.addressed_as_target = 1'b0;
		end
		if (apb_rd && hit_idx == `IIC_IDX_SR2) begin
			s2_d.ack_failure = 1'b0;
			s2_d.stop_seen = 1'b0;
			s2_d.arbitration_lost = 1'b0;
			s2_d.bus_error_flag = 1'b0;
			s2rd_d = 1'b1;
		end

		// bus events; hardware sets come after clears so they win
		if (cr_q.unit_enable) begin
			if (start_det) begin
				s1_d.bus_busy = 1'b1;
				if (misplaced) begin
					s2_d.bus_error_flag = 1'b1;
					s1_d.bus_busy = 1'b0;
				end
				eng_d.xfer = 1'b1;
				eng_d.addr_ph = 1'b1;
				eng_d.cnt = 4'h0;
				eng_d.tgt_sel = 1'b0;
				eng_d.tx = 1'b0;
				eng_d.tx_wait = 1'b0;
				eng_d.sda_low = 1'b0;
			end
			if (stop_det) begin
				s1_d.bus_busy = 1'b0;
				if (misplaced) begin
					s2_d.bus_error_flag = 1'b1;
				end
				if (eng_q.tgt_sel && !role && cr_q.ack_en) begin
					s2_d.stop_seen = 1'b1;
				end
				s1_d.controller_role = 1'b0;
				s1_d.direction_sent_flag = 1'b0;
				s2_d.broadcast_addressed = 1'b0;
				eng_d.xfer = 1'b0;
				eng_d.tgt_sel = 1'b0;
				eng_d.tx_wait = 1'b0;
				eng_d.sda_low = 1'b0;
			end
			if (scl_rise && eng_q.xfer) begin
				if (eng_q.cnt < `IIC_ACK_BIT) begin
					if (eng_q.tx && role && eng_q.sh[7] && !sda_s_q) begin
						s2_d.arbitration_lost = 1'b1;
						s1_d.controller_role = 1'b0;
						s1_d.direction_sent_flag = 1'b0;
						eng_d.tx = 1'b0;
						eng_d.clk_low = 1'b0;
					end
					eng_d.sh = {eng_q.sh[6:0], sda_s_q};
					eng_d.cnt = eng_q.cnt + 4'h1;
				end else if (eng_q.cnt == `IIC_ACK_BIT) begin
					eng_d.ackok = !sda_s_q; // no arbitration on the ack bit
					eng_d.cnt = `IIC_END_BIT;
				end
			end
			if (scl_fall && eng_q.xfer) begin
				if (eng_q.cnt < `IIC_ACK_BIT) begin
					eng_d.sda_low = eng_q.tx && !eng_q.sh[7];
				end else if (eng_q.cnt == `IIC_ACK_BIT) begin
					eng_d.sda_low = !eng_q.tx && cr_q.ack_en && (!eng_q.addr_ph || match);
				end else begin
					eng_d.sda_low = 1'b0;
					eng_d.cnt = 4'h0;
					if (eng_q.addr_ph && !role) begin
						if (match && cr_q.ack_en) begin
							s1_d.addressed_as_target = 1'b1;
							s2_d.broadcast_addressed = is_gc;
							eng_d.tgt_sel = 1'b1;
							eng_d.addr_ph = 1'b0;
							eng_d.tx = eng_q.sh[0] && !is_gc;
							eng_d.tx_wait = eng_q.sh[0] && !is_gc;
						end else begin
							eng_d.xfer = 1'b0;
						end
					end else if (eng_q.addr_ph) begin
						if (!eng_q.ackok) begin
							s2_d.ack_failure = 1'b1;
						end else if (eng_q.sh[7:3] == `IIC_HDR_PAT && !eng_q.hdr && !eng_q.sh[0]) begin
							s1_d.ten_bit_header_sent = 1'b1;
							eng_d.hdr = 1'b1;
						end else begin
							eng_d.ev6 = 1'b1;
							eng_d.addr_ph = 1'b0;
							eng_d.hdr = 1'b0;
							eng_d.tx = !eng_q.sh[0];
						end
					end else if (eng_q.tx) begin
						s1_d.byte_done = 1'b1;
						s1_d.direction_sent_flag = 1'b1;
						if (!eng_q.ackok) begin
							s2_d.ack_failure = 1'b1;
							if (!role) begin
								eng_d.xfer = 1'b0;
							end
						end
					end else begin
						dr_d = eng_q.sh;
						if (cr_q.ack_en) begin
							s1_d.byte_done = 1'b1;
							s1_d.direction_sent_flag = 1'b0;
						end
					end
					if (!role && cr_q.stop_req && eng_q.tgt_sel) begin
						eng_d.xfer = 1'b0;
						eng_d.tgt_sel = 1'b0;
					end
				end
			end
		end

		// controller sequencer
		case (st_q)
			iic_pkg::ST_IDLE: begin
				if (cr_q.start_req && cr_q.unit_enable && !s1_q.bus_busy) begin
					st_d = iic_pkg::ST_SETUP;
				end
			end
			iic_pkg::ST_SETUP: begin
				if (tick && scl_s_q && sda_s_q) begin
					st_d = iic_pkg::ST_START1;
				end
			end
			iic_pkg::ST_START1: begin
				if (tick) begin
					st_d = iic_pkg::ST_START2;
				end
			end
			iic_pkg::ST_START2: begin
				if (tick) begin
					s1_d.start_sent = 1'b1;
					cr_d.start_req = 1'b0;
					eng_d.clk_low = 1'b1;
					st_d = cr_q.stop_req ? iic_pkg::ST_STOP1 : iic_pkg::ST_XFER;
				end
			end
			iic_pkg::ST_XFER: begin
				if (!role) begin
					st_d = iic_pkg::ST_IDLE;
				end else if ((hold || s2_q.ack_failure) && eng_q.clk_low && eng_q.cnt == 4'h0) begin
					if (cr_q.start_req) begin
						st_d = iic_pkg::ST_RSTART;
					end else if (cr_q.stop_req) begin
						st_d = iic_pkg::ST_STOP1;
					end
				end else if (eng_q.clk_low && tick) begin
					eng_d.clk_low = 1'b0;
				end else if (!eng_q.clk_low && scl_s_q && tick) begin
					eng_d.clk_low = 1'b1;
				end
			end
			iic_pkg::ST_RSTART: begin
				eng_d.xfer = 1'b0;
				eng_d.sda_low = 1'b0;
				if (tick) begin
					st_d = iic_pkg::ST_SETUP;
				end
			end
			iic_pkg::ST_STOP1: begin
				eng_d.xfer = 1'b0;
				if (tick) begin
					st_d = iic_pkg::ST_STOP2;
				end
			end
			iic_pkg::ST_STOP2: begin
				if (tick && scl_s_q) begin
					cr_d.stop_req = 1'b0;
					s1_d.controller_role = 1'b0;
					// released lines end a pending byte, else clock hold is stale
					s1_d.byte_done = 1'b0;
					s1_d.direction_sent_flag = 1'b0;
					st_d = iic_pkg::ST_IDLE;
				end
			end
			default: st_d = iic_pkg::ST_IDLE;
		endcase

		// disabled unit clears control, status and engine state except the stop request and the busy flag
		if (!cr_d.unit_enable) begin
			cr_d = '{stop_req: cr_d.stop_req, default: 1'b0};
			s1_d = '{bus_busy: s1_q.bus_busy, default: 1'b0};
			s2_d = '0;
			eng_d = '0;
			st_d = iic_pkg::ST_IDLE;
			s1rd_d = 1'b0;
			s2rd_d = 1'b0;
		end
	end

	// line drive, outputs released while disabled
	always_comb begin
		scl_low = cr_q.unit_enable && (st_q == iic_pkg::ST_START2 || st_q == iic_pkg::ST_RSTART
			|| st_q == iic_pkg::ST_STOP1 || (st_q == iic_pkg::ST_XFER && eng_q.clk_low)
			|| (eng_q.xfer && hold));
		sda_low = cr_q.unit_enable && (st_q == iic_pkg::ST_START1 || st_q == iic_pkg::ST_START2
			|| st_q == iic_pkg::ST_STOP1 || st_q == iic_pkg::ST_STOP2
			|| (st_q != iic_pkg::ST_RSTART && eng_q.xfer && eng_q.sda_low));
		irq_d = cr_q.irq_enable && ev_any;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cr_q <= `IIC_CR_RST;
			s1_q <= '0;
			s2_q <= '0;
			eng_q <= '0;
			st_q <= iic_pkg::ST_IDLE;
			dr_q <= `IIC_DR_RST;
			oar_q <= `IIC_OAR_RST;
			ccr_q <= `IIC_CCR_RST;
			div_q <= 8'h00;
			prdata_q <= 32'h0000_0000;
			s1rd_q <= 1'b0;
			s2rd_q <= 1'b0;
			irq_q <= 1'b0;
			scl_oe_n_q <= 1'b1;
			sda_oe_n_q <= 1'b1;
		end else begin
			cr_q <= cr_d;
			s1_q <= s1_d;
			s2_q <= s2_d;
			eng_q <= eng_d;
			st_q <= st_d;
			dr_q <= dr_d;
			oar_q <= oar_d;
			ccr_q <= ccr_d;
			div_q <= div_d;
			prdata_q <= prdata_d;
			s1rd_q <= s1rd_d;
			s2rd_q <= s2rd_d;
			irq_q <= irq_d;
			scl_oe_n_q <= !scl_low;
			sda_oe_n_q <= !sda_low;
		end
	end

	assign prdata = prdata_q;
	assign irq = irq_q;
	assign scl_o = 1'b0;
	assign sda_o = 1'b0;
	assign scl_oe_n = scl_oe_n_q;
	assign sda_oe_n = sda_oe_n_q;

endmodule : iic_ctrl

// ===== bench/iic_ctrl_checker.sv
// port assertions for the two-wire control logic
`timescale 1ns/1ps
module iic_ctrl_checker (
	input wire logic pclk, // clock
	input wire logic presetn, // reset
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [7:0] paddr, // apb address
	input wire logic [31:0] pwdata, // apb write data
	input wire logic [31:0] prdata, // apb read data
	input wire logic scl_oe_n, // clock pull low
	input wire logic sda_oe_n, // data pull low
	input wire logic irq // interrupt
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic acc, wr_cr, rd_cr, rd_s1, rd_st;
	logic [3:0] cfg_d, cfg_q; // enable, irq enable, stop, first write
	assign acc = psel && penable;
	assign wr_cr = acc && pwrite && paddr == 8'h00;
	assign rd_cr = acc && !pwrite && paddr == 8'h00;
	assign rd_s1 = acc && !pwrite && paddr == 8'h04;
	assign rd_st = acc && !pwrite && (paddr == 8'h04 || paddr == 8'h08);
	always_comb begin
		cfg_d = cfg_q;
		if (wr_cr)
			cfg_d = {pwdata[5], cfg_q[3] & pwdata[5] & pwdata[0], cfg_q[3] ? pwdata[1] : cfg_q[1],
				!cfg_q[3] & pwdata[5]};
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cfg_q <= 4'h0;
		else
			cfg_q <= cfg_d;
	end
	a_off_released: assert property (!cfg_q[3] && !$past(cfg_q[3]) |-> scl_oe_n && sda_oe_n)
		else $error("lines driven while disabled");
	a_off_status: assert property (!cfg_q[3] && !$past(cfg_q[3], 2) && rd_st |-> (prdata[7:0] & 8'hef) == 8'h00)
		else $error("status kept while disabled");
	a_off_control: assert property (!cfg_q[3] && !$past(cfg_q[3], 2) && rd_cr |-> prdata[7:0] == {6'h00, cfg_q[1], 1'b0})
		else $error("control not cleared while disabled");
	a_first_write: assert property (cfg_q[0] && rd_cr |-> prdata[7:0] == 8'h20)
		else $error("first enabling write took other bits");
	a_irq_mirror: assert property (cfg_q[2] && rd_s1 |-> irq == prdata[7])
		else $error("irq differs from event flag");
	a_irq_masked: assert property (!cfg_q[2] |=> !irq)
		else $error("irq while masked");
	a_stretch_hold: assert property (rd_s1 && !cfg_q[1] && (prdata[0] || prdata[2] || prdata[3] || prdata[6]) |-> !scl_oe_n)
		else $error("clock not held with flag set");
	a_dir_with_done: assert property (rd_s1 && !prdata[3] |-> !prdata[5])
		else $error("direction shown without byte done");
endmodule : iic_ctrl_checker

// ===== bench/iic_bus_model.sv
// target on the far side of the bus, acknowledges on request
`timescale 1ns/1ps
module iic_bus_model (
	input wire logic scl, // bus clock line
	input wire logic sda, // bus data line
	input wire logic ack_on, // answer with acknowledge
	output logic sda_rel, // 1 releases data line
	output logic [7:0] last_byte // last byte taken
);
	logic [3:0] cnt;
	logic [7:0] sh;
	initial begin
		cnt = 4'h0;
		sh = 8'h00;
		sda_rel = 1'b1;
		last_byte = 8'h00;
	end
	// start condition restarts framing
	always @(negedge sda)
		if (scl)
			cnt = 4'h0;
	always @(posedge scl)
		if (cnt < 4'h8) begin
			sh = {sh[6:0], sda};
			cnt = cnt + 4'h1;
		end
	always @(negedge scl)
		if (cnt == 4'h8) begin
			last_byte = sh;
			sda_rel = !ack_on;
			cnt = 4'h9;
		end else if (cnt == 4'h9) begin
			sda_rel = 1'b1;
			cnt = 4'h0;
		end
endmodule : iic_bus_model

// ===== bench/iic_ctrl_bench.sv
// self-checking bench for the two-wire control logic
`timescale 1ns/1ps
module iic_ctrl_bench;
	logic pclk, presetn, psel, penable, pwrite, ack_on, err;
	logic pready, pslverr, scl_o, scl_oe_n, sda_o, sda_oe_n, irq, sda_rel;
	logic [7:0] paddr, r, a, d, seen;
	logic [31:0] pwdata, prdata;
	wire scl_w = scl_oe_n ? 1'b1 : scl_o;
	wire sda_w = (sda_oe_n ? 1'b1 : sda_o) & sda_rel;
	int seed, mismatches, checks;
	always #10 pclk = ~pclk;
	iic_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.scl_i(scl_w), .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_i(sda_w), .sda_o(sda_o),
		.sda_oe_n(sda_oe_n), .irq(irq));
	iic_bus_model u_far (.scl(scl_w), .sda(sda_w), .ack_on(ack_on), .sda_rel(sda_rel), .last_byte(seen));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk
	task automatic stop_test;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : stop_test
	task automatic hang;
		mismatches++;
		$display("MISMATCH %0t wait ran out", $time);
		stop_test;
	endtask : hang
	task automatic apb(input logic w, input logic [7:0] ad, input logic [7:0] wd);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= {24'h000000, wd};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20)
			hang;
		r = prdata[7:0];
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic poll(input logic [7:0] ad, input logic [7:0] m, input logic [7:0] v);
		int n;
		n = 0;
		do begin
			apb(1'b0, ad, 8'h00);
			n++;
		end while ((r & m) !== v && n < 200);
		if (n >= 200)
			hang;
	endtask : poll
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		ack_on = 1'b1;
		seed = 64;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int i = 0; i < 3; i++) begin
			apb(1'b0, 8'(i * 4), 8'h00);
			chk(r, 8'h00, "reset value");
		end
		apb(1'b0, 8'h18, 8'h00);
		chk({7'h00, err}, 8'h01, "unmapped error");
		chk(r, 8'h00, "unmapped data");
		d = $random(seed);
		apb(1'b1, 8'h10, d);
		apb(1'b0, 8'h10, 8'h00);
		chk(r, d, "own address");
		$display("test reset done");
		apb(1'b1, 8'h00, 8'h3f);
		apb(1'b0, 8'h00, 8'h00);
		chk(r, 8'h20, "first enable");
		chk({7'h00, scl_oe_n & sda_oe_n}, 8'h01, "idle lines");
		apb(1'b1, 8'h00, 8'h25);
		apb(1'b0, 8'h00, 8'h00);
		chk(r, 8'h25, "second enable");
		$display("test enable done");
		for (int k = 0; k < 4; k++) begin
			ack_on <= (k != 3);
			a = $random(seed);
			d = $random(seed);
			a[0] = 1'b0;
			// keep clear of the ten-bit header pattern
			if (a[7:3] == 5'h1e)
				a[7] = 1'b0;
			apb(1'b1, 8'h00, 8'h2d);
			poll(8'h04, 8'h01, 8'h01);
			chk(r, 8'h93, "start flags");
			chk({7'h00, irq}, 8'h01, "irq raised");
			apb(1'b0, 8'h00, 8'h00);
			chk(r, 8'h25, "start cleared");
			apb(1'b1, 8'h14, a);
			if (k == 3) begin
				poll(8'h08, 8'h10, 8'h10);
				apb(1'b0, 8'h08, 8'h00);
				chk(r, 8'h00, "nack cleared");
			end else begin
				poll(8'h04, 8'h80, 8'h80);
				chk(seen, a, "address on wire");
				apb(1'b1, 8'h00, 8'h25);
				apb(1'b1, 8'h14, d);
				poll(8'h04, 8'h08, 8'h08);
				chk(r, 8'hba, "byte done");
				chk(seen, d, "data on wire");
			end
			apb(1'b1, 8'h00, 8'h27);
			poll(8'h04, 8'h12, 8'h00);
			apb(1'b0, 8'h00, 8'h00);
			chk(r, 8'h25, "stop cleared");
			$display("test transfer %0d done", k);
		end
		apb(1'b1, 8'h00, 8'h33);
		apb(1'b1, 8'h00, 8'h02);
		apb(1'b0, 8'h00, 8'h00);
		chk(r, 8'h02, "stop kept off");
		apb(1'b0, 8'h04, 8'h00);
		chk(r & 8'hef, 8'h00, "status off");
		chk({6'h00, scl_oe_n, sda_oe_n}, 8'h03, "lines released");
		chk({7'h00, irq}, 8'h00, "irq off");
		apb(1'b1, 8'h00, 8'h00);
		$display("test disable done");
		stop_test;
	end
endmodule : iic_ctrl_bench
bind iic_ctrl iic_ctrl_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
	.scl_oe_n, .sda_oe_n, .irq);
